// [design/rsw_pkg.sv]
package rsw_pkg;

   // Register map of the AXI4-Lite slave.
   localparam int RSW_AW = 8;
   localparam logic [7:0] RSW_OFF_CTRL = 8'h00;
   localparam logic [7:0] RSW_OFF_DIV = 8'h04;
   localparam logic [7:0] RSW_OFF_STAT = 8'h08;

   // Control register fields.
   localparam int RSW_CTRL_MODE_LSB = 0;
   localparam int RSW_CTRL_HOLD_EN = 3;
   localparam int RSW_CTRL_FORCE_HOLD = 4;
   localparam int RSW_CTRL_LLD_DIS = 5;
   localparam int RSW_CTRL_RAIL_EN = 6;
   localparam int RSW_CTRL_PIN_INV = 7;
   localparam int RSW_CTRL_EN_LSB = 8;
   localparam int RSW_CTRL_DIR0 = 10;
   localparam int RSW_CTRL_DIR1 = 11;
   localparam int RSW_CTRL_LDPIN_HOLD = 12;
   localparam int RSW_CTRL_W = 13;
   localparam logic [12:0] RSW_CTRL_RST = 13'h0300;

   // Pre-divider register fields.
   localparam int RSW_DIV0_LSB = 0;
   localparam int RSW_DIV1_LSB = 2;
   localparam int RSW_DIV_W = 4;
   localparam logic [3:0] RSW_DIV_RST = 4'h0;

   // Status register fields.
   localparam int RSW_STAT_ACTIVE = 0;
   localparam int RSW_STAT_HOLD = 1;
   localparam int RSW_STAT_LOCK = 2;
   localparam int RSW_STAT_RUN_LSB = 3;
   localparam int RSW_STAT_PIN_LSB = 5;
   localparam int RSW_STAT_PEND = 7;

   // Selection modes.
   localparam logic [2:0] RSW_MODE_MAN0 = 3'h0;
   localparam logic [2:0] RSW_MODE_MAN1 = 3'h1;
   localparam logic [2:0] RSW_MODE_PIN = 3'h3;
   localparam logic [2:0] RSW_MODE_AUTO = 3'h4;

   // Select pin codes as {pin1, pin0}.
   localparam logic [1:0] RSW_PINS_IN0 = 2'h0;
   localparam logic [1:0] RSW_PINS_IN1 = 2'h1;
   localparam logic [1:0] RSW_PINS_RESV = 2'h2;
   localparam logic [1:0] RSW_PINS_HOLD = 2'h3;

   // Pre-divider ratio codes: 1, 2, 4, 8.
   localparam logic [1:0] RSW_DIV_BY1 = 2'h0;

   // AXI responses.
   localparam logic [1:0] RSW_RESP_OKAY = 2'h0;
   localparam logic [1:0] RSW_RESP_SLVERR = 2'h2;

endpackage

// [design/rsw_prediv.sv]
`timescale 1ns/1ps
`default_nettype none

module rsw_prediv
   import rsw_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Reference and ratio.
   input wire logic ref_in,
   input wire logic [1:0] ratio,
   // Divided reference.
   output logic div_out
);

   logic ref_d_r;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic div_nxt;
   logic rise;

   // Each bit of the edge counter halves the rate of the one below it.
   assign rise = ref_in & ~ref_d_r;
   assign cnt_nxt = rise ? cnt_r + 3'h1 : cnt_r;
   assign div_nxt = (ratio == RSW_DIV_BY1) ? ref_in : cnt_nxt[ratio - 2'h1];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ref_d_r <= 1'b0;
         cnt_r <= 3'h0;
         div_out <= 1'b0;
      end
      else if (ce)
      begin
         ref_d_r <= ref_in;
         cnt_r <= cnt_nxt;
         div_out <= div_nxt;
      end
   end

endmodule

`default_nettype wire

// [design/rsw_ref_switch.sv]
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rsw_ref_switch
   import rsw_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write channels.
   input wire logic [RSW_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [RSW_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Reference inputs and external select pins.
   input wire logic reference_input_0,
   input wire logic reference_input_1,
   input wire logic select_pin_0,
   input wire logic select_pin_1,
   // First loop conditions.
   input wire logic loop_lock_raw,
   input wire logic tune_rail_cross,
   input wire logic holdover_exit_ok,
   // Selection results and status.
   output logic active_ref_clk,
   output logic [1:0] ref_buffer_run,
   output logic active_input,
   output logic switch_event,
   output logic holdover_status,
   output logic first_loop_lock_detect,
   output logic lock_status_pin
);

   logic [RSW_CTRL_W-1:0] ctrl_r;
   logic [RSW_DIV_W-1:0] div_r;
   logic [RSW_AW-1:0] aw_addr_r;
   logic aw_full_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_full_r;
   logic [2:0] mode_prev_r;
   logic [1:0] pins_prev_r;
   logic armed_r;
   logic pend_valid_r;
   logic pend_sel_r;
   logic [1:0] div_out;
   logic active_nxt;
   logic pend_valid_nxt;
   logic pend_sel_nxt;
   logic holdover_nxt;

   // Byte-lane merge of a write into a register.
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Next enabled input after the current one, wrapping toward input 0.
   function automatic logic next_enabled(input logic cur,
                                         input logic [1:0] en);
      logic res;
      res = cur;
      if (en[~cur])
      begin
         res = ~cur;
      end
      return res;
   endfunction

   // Configuration fields.
   wire [2:0] mode = ctrl_r[RSW_CTRL_MODE_LSB +: 3];
   wire hold_en = ctrl_r[RSW_CTRL_HOLD_EN];
   wire force_hold = ctrl_r[RSW_CTRL_FORCE_HOLD];
   wire lock_loss_detect_disable = ctrl_r[RSW_CTRL_LLD_DIS];
   wire tune_rail_detect_enable = ctrl_r[RSW_CTRL_RAIL_EN];
   wire [1:0] ref_input_enable = ctrl_r[RSW_CTRL_EN_LSB +: 2];
   wire [1:0] select_pin_direction = {ctrl_r[RSW_CTRL_DIR1],
                                      ctrl_r[RSW_CTRL_DIR0]};
   wire ldpin_hold = ctrl_r[RSW_CTRL_LDPIN_HOLD];

   wire is_manual = (mode == RSW_MODE_MAN0) || (mode == RSW_MODE_MAN1);
   wire is_pin = (mode == RSW_MODE_PIN);
   wire is_auto = (mode == RSW_MODE_AUTO);

   // Pre-dividers, one per reference input.
   wire [1:0] ref_in = {reference_input_1, reference_input_0};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_div
         rsw_prediv u_div (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .ref_in(ref_in[gi]),
            .ratio(div_r[2*gi +: 2]),
            .div_out(div_out[gi])
         );
      end
   endgenerate

   // A pin set as output reads zero; inversion is not applied here.
   wire [1:0] pins_eff = {select_pin_1 & ~select_pin_direction[1],
                          select_pin_0 & ~select_pin_direction[0]};
   wire pin_hold = is_pin && (pins_eff == RSW_PINS_HOLD);
   wire pin_tgt_ok = (pins_eff == RSW_PINS_IN0) ||
                     (pins_eff == RSW_PINS_IN1);
   wire pin_change = is_pin && (pins_eff != pins_prev_r) &&
                     (pins_eff != RSW_PINS_RESV);

   // Lock seen at first_loop_lock_detect is held low in holdover.
   wire lock_gate = loop_lock_raw & ~holdover_status;
   wire lock_fall = first_loop_lock_detect & ~lock_gate & armed_r &
                    ~lock_loss_detect_disable;
   wire rail_trip = tune_rail_detect_enable & tune_rail_cross;

   wire pin_evt = pin_change | (is_pin & lock_fall);
   wire auto_start = is_auto && (mode_prev_r != RSW_MODE_AUTO);
   wire auto_evt = is_auto & ~auto_start & lock_fall;
   wire any_evt = pin_evt | auto_evt;

   wire evt_hold = (is_manual & lock_fall) | pin_evt | auto_evt;
   wire hold_set = force_hold | pin_hold |
                   (hold_en & (rail_trip | evt_hold));
   wire hold_clr = holdover_status & (holdover_exit_ok | ~hold_en) &
                   ~force_hold & ~pin_hold;
   wire hold_end = hold_clr & ~hold_set;

   // Active input and pending pin target.
   always_comb
   begin
      active_nxt = active_input;
      pend_valid_nxt = pend_valid_r & is_pin;
      pend_sel_nxt = pend_sel_r;
      holdover_nxt = hold_set | (holdover_status & ~hold_clr);
      if (is_manual)
      begin
         active_nxt = mode[0];
      end
      else if (is_pin)
      begin
         if (pin_evt && pin_tgt_ok)
         begin
            if (hold_en)
            begin
               pend_valid_nxt = 1'b1;
               pend_sel_nxt = pins_eff[0];
            end
            else
            begin
               active_nxt = pins_eff[0];
               pend_valid_nxt = 1'b0;
            end
         end
         else if (hold_end && pend_valid_r)
         begin
            active_nxt = pend_sel_r;
            pend_valid_nxt = 1'b0;
         end
      end
      else if (is_auto)
      begin
         if (auto_start)
         begin
            if (!first_loop_lock_detect)
            begin
               active_nxt = ref_input_enable[0] ? 1'b0 :
                            (ref_input_enable[1] ? 1'b1 : active_input);
            end
         end
         else if (auto_evt)
         begin
            active_nxt = next_enabled(active_input, ref_input_enable);
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         active_input <= 1'b0;
         pend_valid_r <= 1'b0;
         pend_sel_r <= 1'b0;
         holdover_status <= 1'b0;
         first_loop_lock_detect <= 1'b0;
         armed_r <= 1'b0;
         switch_event <= 1'b0;
         mode_prev_r <= RSW_MODE_MAN0;
         pins_prev_r <= RSW_PINS_IN0;
         active_ref_clk <= 1'b0;
      end
      else if (ce)
      begin
         active_input <= active_nxt;
         pend_valid_r <= pend_valid_nxt;
         pend_sel_r <= pend_sel_nxt;
         holdover_status <= holdover_nxt;
         first_loop_lock_detect <= lock_gate;
         armed_r <= lock_gate | (armed_r & ~lock_fall);
         switch_event <= any_evt;
         mode_prev_r <= mode;
         pins_prev_r <= pins_eff;
         active_ref_clk <= div_out[active_nxt];
      end
   end

   // Selected buffer runs in manual and pin modes even when disabled.
   wire force_run = is_manual | is_pin;
   assign ref_buffer_run = ref_input_enable |
                           ({active_input, ~active_input} &
                            {2{force_run}});
   assign lock_status_pin = ldpin_hold ? holdover_status :
                            first_loop_lock_detect;

   // AXI4-Lite slave: address and data are latched in either order.
   assign awready = ce & ~aw_full_r & ~bvalid;
   assign wready = ce & ~w_full_r & ~bvalid;
   assign arready = ce & ~rvalid;
   wire do_write = aw_full_r & w_full_r & ~bvalid;
   wire wr_ctrl = do_write && (aw_addr_r == RSW_OFF_CTRL);
   wire wr_div = do_write && (aw_addr_r == RSW_OFF_DIV);
   wire wr_ok = wr_ctrl || wr_div || (aw_addr_r == RSW_OFF_STAT);
   wire [31:0] ctrl_wide = lane_merge({19'h0, ctrl_r}, w_data_r, w_strb_r);
   wire [31:0] div_wide = lane_merge({28'h0, div_r}, w_data_r, w_strb_r);
   wire [31:0] stat_word = {24'h0, pend_valid_r, pins_eff, ref_buffer_run,
                            first_loop_lock_detect, holdover_status,
                            active_input};
   wire rd_ctrl = (araddr == RSW_OFF_CTRL);
   wire rd_div = (araddr == RSW_OFF_DIV);
   wire rd_stat = (araddr == RSW_OFF_STAT);
   wire [31:0] rd_word = rd_ctrl ? {19'h0, ctrl_r} :
                         rd_div ? {28'h0, div_r} :
                         rd_stat ? stat_word : 32'h0;
   wire rd_ok = rd_ctrl | rd_div | rd_stat;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r <= RSW_CTRL_RST;
         div_r <= RSW_DIV_RST;
         aw_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_full_r <= 1'b0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RSW_RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RSW_RESP_OKAY;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_full_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         if (do_write)
         begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? RSW_RESP_OKAY : RSW_RESP_SLVERR;
         end
         else if (bvalid && bready)
         begin
            bvalid <= 1'b0;
         end
         if (wr_ctrl)
         begin
            ctrl_r <= ctrl_wide[RSW_CTRL_W-1:0];
         end
         if (wr_div)
         begin
            div_r <= div_wide[RSW_DIV_W-1:0];
         end
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_ok ? RSW_RESP_OKAY : RSW_RESP_SLVERR;
         end
         else if (rvalid && rready)
         begin
            rvalid <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence pin_move_s;
      ce && pin_change && pin_tgt_ok && !hold_en && !force_hold;
   endsequence

   sequence auto_loss_s;
      ce && auto_evt && (ref_input_enable != 2'h0);
   endsequence

   manual_select_a: assert property (
      (ce && is_manual) |=> (active_input == $past(mode[0])))
      else $error("manual mode picked the wrong input");

   buffer_run_a: assert property (
      force_run |-> ref_buffer_run[active_input])
      else $error("selected input buffer not running");

   pin_event_a: assert property (
      (ce && pin_change) |=> switch_event)
      else $error("select pin change raised no event");

   pin_direct_a: assert property (
      pin_move_s |=> (active_input == $past(pins_eff[0])))
      else $error("pin switch without holdover not immediate");

   pin_output_a: assert property (
      select_pin_direction[0] |-> !pins_eff[0])
      else $error("output pin not read as zero");

   lld_block_a: assert property (
      (ce && is_manual && lock_loss_detect_disable && !holdover_status &&
       !force_hold && !rail_trip) |=> !holdover_status)
      else $error("lock fall entered holdover while disabled");

   auto_target_a: assert property (
      auto_loss_s |=> ref_input_enable[active_input])
      else $error("automatic switch to disabled input");

   hold_lock_a: assert property (
      (ce && holdover_status) |=> !first_loop_lock_detect)
      else $error("lock detect high during holdover");

   force_hold_a: assert property (
      (ce && force_hold) |=> holdover_status)
      else $error("force bit did not enter holdover");

   undef_mode_a: assert property (
      (ce && !is_manual && !is_pin && !is_auto) |=>
         (!switch_event && $stable(active_input)))
      else $error("undefined mode changed selection");

endmodule

`default_nettype wire

// [dv/rsw_ref_host.sv]
`timescale 1ns/1ps
`default_nettype none

module rsw_ref_host
   import rsw_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Requested select levels as {pin1, pin0}.
   input wire logic [1:0] pins_req,
   // Reference clocks and select pins.
   output logic ref0,
   output logic ref1,
   output logic sel0,
   output logic sel1
);
   logic [1:0] ph_r;

   // Input 0 toggles every cycle, input 1 every second cycle.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ph_r <= 2'h0;
      else
         ph_r <= ph_r + 2'h1;
   end
   assign ref0 = ph_r[0];
   assign ref1 = ph_r[1];

   // The host drives both select pins at all times, whatever direction the device gives them.
   always_ff @(posedge aclk)
   begin
      {sel1, sel0} <= pins_req;
   end
endmodule
`default_nettype wire

// [dv/rsw_ref_switch_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module rsw_ref_switch_tb_top
   import rsw_pkg::*;
   ;
   localparam logic [31:0] f_ho = 32'h1 << RSW_CTRL_HOLD_EN;
   localparam logic [31:0] f_fh = 32'h1 << RSW_CTRL_FORCE_HOLD;
   localparam logic [31:0] f_ld = 32'h1 << RSW_CTRL_LLD_DIS;
   localparam logic [31:0] f_rl = 32'h1 << RSW_CTRL_RAIL_EN;
   localparam logic [31:0] f_inv = 32'h1 << RSW_CTRL_PIN_INV;
   localparam logic [31:0] f_dir = 32'h1 << RSW_CTRL_DIR0;
   localparam logic [31:0] f_ldp = 32'h1 << RSW_CTRL_LDPIN_HOLD;
   logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, active_ref_clk, active_input;
   logic [RSW_AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, pins_req, ref_buffer_run;
   logic reference_input_0, reference_input_1, select_pin_0, select_pin_1;
   logic loop_lock_raw, tune_rail_cross, holdover_exit_ok, switch_event;
   logic holdover_status, first_loop_lock_detect, lock_status_pin;
   int err_count, check_count, ev_cnt, e0, p;

   rsw_ref_switch rsw_ref_switch_inst (
      .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .reference_input_0,
      .reference_input_1, .select_pin_0, .select_pin_1, .loop_lock_raw,
      .tune_rail_cross, .holdover_exit_ok, .active_ref_clk,
      .ref_buffer_run, .active_input, .switch_event, .holdover_status,
      .first_loop_lock_detect, .lock_status_pin);

   rsw_ref_host rsw_ref_host_inst (.aclk, .aresetn, .pins_req,
      .ref0(reference_input_0), .ref1(reference_input_1),
      .sel0(select_pin_0), .sel1(select_pin_1));

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ev_cnt <= 0;
      end
      else if (switch_event === 1'b1)
      begin
         ev_cnt <= ev_cnt + 1;
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic cb(input logic seen, input logic exp);
      chk(32'(seen), 32'(exp));
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic drv(input logic [1:0] pv, input logic l, x, r);
      @(posedge aclk);
      pins_req <= pv;
      loop_lock_raw <= l;
      holdover_exit_ok <= x;
      tune_rail_cross <= r;
   endtask

   function automatic logic [31:0] cw(input logic [2:0] m,
      input logic [31:0] f, input logic [1:0] en);
      return 32'(m) | f | (32'(en) << RSW_CTRL_EN_LSB);
   endfunction

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic ad, wd;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1)
         begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, ed);
      chk(32'(rresp), 32'(er));
   endtask

   // Cycles between two rising edges of the selected divided reference.
   task automatic period(output int pr);
      int r1;
      logic prv;
      pr = 0;
      r1 = -1;
      prv = 1'b1;
      wt(16);
      for (int k = 0; k < 40; k++)
      begin
         wt(1);
         if (active_ref_clk === 1'b1 && prv === 1'b0 && r1 < 0)
            r1 = k;
         else if (active_ref_clk === 1'b1 && prv === 1'b0 && pr == 0)
            pr = k - r1;
         prv = active_ref_clk;
      end
   endtask

   initial
   begin
      #400000;
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      {err_count, check_count} = '0;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, pins_req} = '0;
      {loop_lock_raw, tune_rail_cross, holdover_exit_ok} = '0;
      ce = 1'b1;
      wstrb = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axr(RSW_OFF_CTRL, 32'h300, RSW_RESP_OKAY);
      axr(RSW_OFF_DIV, 32'h0, RSW_RESP_OKAY);
      axr(RSW_OFF_STAT, 32'h18, RSW_RESP_OKAY);
      axr(8'h0c, 32'h0, RSW_RESP_SLVERR);
      axw(8'h0c, 32'h0, RSW_RESP_SLVERR);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN1, 0, 2'h0), RSW_RESP_OKAY);
      wt(6);
      cb(active_input, 1'b1);
      chk(32'(ref_buffer_run), 32'h2);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN0, 0, 2'h0), RSW_RESP_OKAY);
      wt(6);
      cb(active_input, 1'b0);
      chk(32'(ref_buffer_run), 32'h1);
      for (int c = 0; c < 4; c++)
      begin
         axw(RSW_OFF_DIV, 32'(c), RSW_RESP_OKAY);
         period(p);
         chk(32'(p), 32'(2 << c));
      end
      axw(RSW_OFF_DIV, 32'h4, RSW_RESP_OKAY);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN1, 0, 2'h0), RSW_RESP_OKAY);
      period(p);
      chk(32'(p), 32'h8);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_PIN, f_ld | f_inv, 0), RSW_RESP_OKAY);
      wt(6);
      e0 = ev_cnt;
      drv(2'h1, 0, 0, 0);
      wt(6);
      cb(active_input, 1'b1);
      chk(ev_cnt, e0 + 1);
      chk(32'(ref_buffer_run), 32'h2);
      drv(2'h2, 0, 0, 0);
      wt(6);
      cb(active_input, 1'b1);
      chk(ev_cnt, e0 + 1);
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(active_input, 1'b0);
      chk(ev_cnt, e0 + 2);
      drv(2'h3, 0, 0, 0);
      wt(6);
      cb(holdover_status, 1'b1);
      drv(2'h0, 0, 0, 0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_PIN, f_ld | f_dir, 0), RSW_RESP_OKAY);
      drv(2'h1, 0, 0, 0);
      wt(6);
      cb(active_input, 1'b0);
      axr(RSW_OFF_STAT, 32'h8, RSW_RESP_OKAY);
      drv(2'h0, 1, 0, 0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_PIN, f_ho | f_ld | f_ldp, 3),
         RSW_RESP_OKAY);
      wt(6);
      drv(2'h1, 1, 0, 0);
      wt(6);
      cb(holdover_status, 1'b1);
      cb(active_input, 1'b0);
      cb(first_loop_lock_detect, 1'b0);
      cb(lock_status_pin, 1'b1);
      drv(2'h1, 1, 1, 0);
      wt(6);
      cb(holdover_status, 1'b0);
      cb(active_input, 1'b1);
      cb(first_loop_lock_detect, 1'b1);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN0, f_fh | f_ld, 3), RSW_RESP_OKAY);
      wt(6);
      cb(holdover_status, 1'b1);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN0, f_ld, 3), RSW_RESP_OKAY);
      drv(2'h0, 1, 0, 0);
      wt(6);
      cb(holdover_status, 1'b0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN1, f_ho | f_ld, 3), RSW_RESP_OKAY);
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(holdover_status, 1'b0);
      drv(2'h0, 1, 0, 0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN1, f_ho, 3), RSW_RESP_OKAY);
      wt(6);
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(holdover_status, 1'b1);
      drv(2'h0, 1, 1, 0);
      wt(6);
      cb(holdover_status, 1'b0);
      cb(active_input, 1'b1);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN1, f_ho | f_ld | f_rl, 3),
         RSW_RESP_OKAY);
      drv(2'h0, 1, 0, 1);
      wt(6);
      cb(holdover_status, 1'b1);
      drv(2'h0, 1, 0, 0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_MAN0, 0, 3), RSW_RESP_OKAY);
      wt(6);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_AUTO, 0, 3), RSW_RESP_OKAY);
      wt(6);
      cb(active_input, 1'b0);
      e0 = ev_cnt;
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(active_input, 1'b1);
      wt(6);
      chk(ev_cnt, e0 + 1);
      drv(2'h0, 1, 0, 0);
      wt(6);
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(active_input, 1'b0);
      chk(ev_cnt, e0 + 2);
      drv(2'h0, 1, 0, 0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_AUTO, 0, 1), RSW_RESP_OKAY);
      wt(6);
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(active_input, 1'b0);
      drv(2'h0, 1, 0, 0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_AUTO, f_ld, 3), RSW_RESP_OKAY);
      wt(6);
      e0 = ev_cnt;
      drv(2'h0, 0, 0, 0);
      wt(6);
      chk(ev_cnt, e0);
      drv(2'h0, 1, 0, 0);
      axw(RSW_OFF_CTRL, cw(RSW_MODE_AUTO, f_ho, 3), RSW_RESP_OKAY);
      wt(6);
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(holdover_status, 1'b1);
      cb(active_input, 1'b1);
      drv(2'h0, 1, 1, 0);
      wt(6);
      cb(holdover_status, 1'b0);
      cb(active_input, 1'b1);
      // With the clock enable low a lock fall must leave all state frozen.
      @(posedge aclk);
      ce <= 1'b0;
      drv(2'h0, 0, 0, 0);
      wt(6);
      cb(first_loop_lock_detect, 1'b1);
      cb(holdover_status, 1'b0);
      cb(active_input, 1'b1);
      drv(2'h0, 1, 1, 0);
      @(posedge aclk);
      ce <= 1'b1;
      axw(RSW_OFF_CTRL, cw(3'h2, f_ld, 3), RSW_RESP_OKAY);
      wt(6);
      e0 = ev_cnt;
      drv(2'h1, 0, 0, 0);
      wt(6);
      chk(ev_cnt, e0);
      cb(active_input, 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
